// File: hw/osc_tune_pkg.sv
// Purpose: Shared constants and types for the fast internal oscillator tuning block
// Assumes: 8-bit register port, one aligned register per address
// Notes: Register addresses are local choices, listed in the hand-over
package osc_tune_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int OSC_COUNT = 5;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_FREQ_SELECT = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_TUNING = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_REQUEST = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT_SOURCE = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_CONTROL = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_READY_FLAGS = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_MANUAL_ENABLES = 4'h6;

  // Field layouts and writable masks
  localparam int FREQ_SEL_W = 3;
  localparam int TRIM_W = 6;
  localparam logic [DATA_W-1:0] MASK_FREQ_SELECT = 8'h07;
  localparam logic [DATA_W-1:0] MASK_TUNING = 8'h3F;
  localparam logic [DATA_W-1:0] MASK_SWITCH_REQUEST = 8'h7F;
  localparam logic [DATA_W-1:0] MASK_SWITCH_CONTROL = 8'h80;
  localparam logic [DATA_W-1:0] MASK_MANUAL_ENABLES = 8'hF4;
  localparam int SWITCH_READY_BIT = 4;
  localparam int SWITCH_PENDING_BIT = 3;

  // Manual enable / ready bit positions, one per oscillator
  localparam int BIT_EXT_OSC = 7;
  localparam int BIT_FAST_OSC = 6;
  localparam int BIT_MID_OSC = 5;
  localparam int BIT_SLOW_OSC = 4;
  localparam int BIT_ADC_OSC = 2;

  // Reset-oscillator configuration codes and the select values they force
  localparam logic [2:0] RESET_OSC_FAST_1MHZ = 3'h6;
  localparam logic [2:0] RESET_OSC_FAST_32MHZ = 3'h0;
  localparam logic [FREQ_SEL_W-1:0] FREQ_SEL_AFTER_1MHZ = 3'h2;
  localparam logic [FREQ_SEL_W-1:0] FREQ_SEL_AFTER_32MHZ = 3'h6;
  localparam logic [FREQ_SEL_W-1:0] FREQ_SEL_OTHER_RESET = 3'h2;

  // Reset values
  localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
  localparam logic [DATA_W-1:0] SWITCH_REQUEST_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SWITCH_CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MANUAL_ENABLES_RESET = 8'h00;

  // Frequency select codes
  localparam logic [FREQ_SEL_W-1:0] FREQ_1MHZ = 3'h0;
  localparam logic [FREQ_SEL_W-1:0] FREQ_2MHZ = 3'h1;
  localparam logic [FREQ_SEL_W-1:0] FREQ_4MHZ = 3'h2;
  localparam logic [FREQ_SEL_W-1:0] FREQ_8MHZ = 3'h3;
  localparam logic [FREQ_SEL_W-1:0] FREQ_12MHZ = 3'h4;
  localparam logic [FREQ_SEL_W-1:0] FREQ_16MHZ = 3'h5;
  localparam logic [FREQ_SEL_W-1:0] FREQ_32MHZ = 3'h6;
  localparam logic [FREQ_SEL_W-1:0] FREQ_RESERVED = 3'h7;

  // Nominal frequency in MHz for each code
  localparam logic [5:0] MHZ_1 = 6'h01;
  localparam logic [5:0] MHZ_2 = 6'h02;
  localparam logic [5:0] MHZ_4 = 6'h04;
  localparam logic [5:0] MHZ_8 = 6'h08;
  localparam logic [5:0] MHZ_12 = 6'h0C;
  localparam logic [5:0] MHZ_16 = 6'h10;
  localparam logic [5:0] MHZ_32 = 6'h20;
  localparam logic [5:0] MHZ_NONE = 6'h00;

  // Trim extremes
  localparam logic [TRIM_W-1:0] TRIM_MAX = 6'h1F;
  localparam logic [TRIM_W-1:0] TRIM_MIN = 6'h20;
  localparam logic [TRIM_W-1:0] TRIM_CENTRE = 6'h00;

  typedef struct packed {
    logic [5:0] stepIndex;
    logic atMax;
    logic atMin;
    logic atCentre;
  } trimStatus_type;

  typedef struct packed {
    logic [5:0] nominalMhz;
    logic reserved;
  } freqInfo_type;

endpackage

// File: hw/osc_request_gate.sv
// Purpose: Run decision for one oscillator
// Assumes: Requests are synchronous to sys_clk
// Notes: Registered output so the run line never glitches
`timescale 1ns/1ps
module osc_request_gate (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic manualOn,
  input wire logic moduleRequest,
  output logic oscRun
);

  logic next_oscRun;

  always_comb begin
    next_oscRun = manualOn | moduleRequest;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      oscRun <= 1'b0;
    end else begin
      oscRun <= next_oscRun;
    end
  end

endmodule

// File: hw/internal_osc_freq_tune.sv
// Purpose: Register control of the fast internal oscillator frequency and trim
// Assumes: Single clock, synchronous active-low reset, one-cycle strobes
// Notes: Clock switch sequencing is not modelled; requests take effect one cycle later unless held by switch control bit 7
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Behaviour
// - Decode select code into nominal frequency
// - Config 110 resets select to 010
// - Config 000 resets select to 110
// - Trim 01 1111 gives highest frequency
// - Trim 10 0000 gives lowest frequency
// - Trim zero is centre, reset default
// - Unused upper bits read as zero
// - Manual enable keeps oscillator running
module internal_osc_freq_tune (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [2:0] resetOscChoice,
  input wire logic [osc_tune_pkg::ADDR_W-1:0] regAddr,
  input wire logic [osc_tune_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [osc_tune_pkg::OSC_COUNT-1:0] oscModuleRequest,
  output logic [osc_tune_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid,
  output logic [osc_tune_pkg::FREQ_SEL_W-1:0] hfFreqSelect,
  output logic [osc_tune_pkg::TRIM_W-1:0] hfTrimValue,
  output osc_tune_pkg::freqInfo_type fastOscFreq,
  output osc_tune_pkg::trimStatus_type fastOscTrim,
  output logic [osc_tune_pkg::OSC_COUNT-1:0] oscRun
);
  import osc_tune_pkg::*;

  // Register storage
  logic [DATA_W-1:0] switchRequest;
  logic [DATA_W-1:0] currentSource;
  logic [DATA_W-1:0] switchControl;
  logic [DATA_W-1:0] manualEnables;
  logic [DATA_W-1:0] next_switchRequest;
  logic [DATA_W-1:0] next_currentSource;
  logic [DATA_W-1:0] next_switchControl;
  logic [DATA_W-1:0] next_manualEnables;
  logic [FREQ_SEL_W-1:0] next_hfFreqSelect;
  logic [TRIM_W-1:0] next_hfTrimValue;

  // Read path
  logic [DATA_W-1:0] next_regRdData;
  logic next_regRdValid;

  // Derived outputs
  freqInfo_type next_fastOscFreq;
  trimStatus_type next_fastOscTrim;
  logic [FREQ_SEL_W-1:0] resetFreqSelect;

  // Oscillator run gating
  logic [OSC_COUNT-1:0] manualVector;
  logic [DATA_W-1:0] readyFlags;
  logic switchPending;

  // Reset value of the select field follows the reset-oscillator strap.
  // The strap is only looked at in the reset cycle, a synchronous load.
  always_comb begin
    unique case (resetOscChoice)
      RESET_OSC_FAST_1MHZ: resetFreqSelect = FREQ_SEL_AFTER_1MHZ;
      RESET_OSC_FAST_32MHZ: resetFreqSelect = FREQ_SEL_AFTER_32MHZ;
      default: resetFreqSelect = FREQ_SEL_OTHER_RESET;
    endcase
  end

  // Frequency select and trim registers
  always_comb begin
    next_hfFreqSelect = hfFreqSelect;
    next_hfTrimValue = hfTrimValue;
    if (regWrite && regAddr == ADDR_FREQ_SELECT) begin
      next_hfFreqSelect = regWrData[FREQ_SEL_W-1:0];
    end
    if (regWrite && regAddr == ADDR_TUNING) begin
      next_hfTrimValue = regWrData[TRIM_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hfFreqSelect <= resetFreqSelect;
      hfTrimValue <= TRIM_RESET;
    end else begin
      hfFreqSelect <= next_hfFreqSelect;
      hfTrimValue <= next_hfTrimValue;
    end
  end

  // Clock-switch registers: only stored and mirrored, no sequencing
  always_comb begin
    next_switchRequest = switchRequest;
    next_switchControl = switchControl;
    next_manualEnables = manualEnables;
    if (regWrite) begin
      unique case (regAddr)
        ADDR_SWITCH_REQUEST: next_switchRequest = regWrData & MASK_SWITCH_REQUEST;
        ADDR_SWITCH_CONTROL: next_switchControl = regWrData & MASK_SWITCH_CONTROL;
        ADDR_MANUAL_ENABLES: next_manualEnables = regWrData & MASK_MANUAL_ENABLES;
        default: begin
        end
      endcase
    end
    // A held switch keeps the old source; otherwise it follows the request
    if (switchControl[DATA_W-1]) begin
      next_currentSource = currentSource;
    end else begin
      next_currentSource = switchRequest;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      switchRequest <= SWITCH_REQUEST_RESET;
      currentSource <= SWITCH_REQUEST_RESET;
      switchControl <= SWITCH_CONTROL_RESET;
      manualEnables <= MANUAL_ENABLES_RESET;
    end else begin
      switchRequest <= next_switchRequest;
      currentSource <= next_currentSource;
      switchControl <= next_switchControl;
      manualEnables <= next_manualEnables;
    end
  end

  assign switchPending = (currentSource != switchRequest);

  // Manual enables per oscillator, in the same order as oscRun
  assign manualVector = {manualEnables[BIT_EXT_OSC], manualEnables[BIT_FAST_OSC],
                         manualEnables[BIT_MID_OSC], manualEnables[BIT_SLOW_OSC],
                         manualEnables[BIT_ADC_OSC]};

  generate
    for (genvar i = 0; i < OSC_COUNT; i++) begin : gateLoop
      osc_request_gate gate (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .manualOn(manualVector[i]),
        .moduleRequest(oscModuleRequest[i]),
        .oscRun(oscRun[i])
      );
    end
  endgenerate

  // Ready flags mirror the running oscillators; no start-up delay is modelled
  always_comb begin
    readyFlags = '0;
    readyFlags[BIT_EXT_OSC] = oscRun[4];
    readyFlags[BIT_FAST_OSC] = oscRun[3];
    readyFlags[BIT_MID_OSC] = oscRun[2];
    readyFlags[BIT_SLOW_OSC] = oscRun[1];
    readyFlags[BIT_ADC_OSC] = oscRun[0];
  end

  // Nominal frequency decode
  always_comb begin
    next_fastOscFreq.reserved = 1'b0;
    unique case (hfFreqSelect)
      FREQ_1MHZ: next_fastOscFreq.nominalMhz = MHZ_1;
      FREQ_2MHZ: next_fastOscFreq.nominalMhz = MHZ_2;
      FREQ_4MHZ: next_fastOscFreq.nominalMhz = MHZ_4;
      FREQ_8MHZ: next_fastOscFreq.nominalMhz = MHZ_8;
      FREQ_12MHZ: next_fastOscFreq.nominalMhz = MHZ_12;
      FREQ_16MHZ: next_fastOscFreq.nominalMhz = MHZ_16;
      FREQ_32MHZ: next_fastOscFreq.nominalMhz = MHZ_32;
      FREQ_RESERVED: begin
        // Reserved code is stored but flagged; the oscillator has no rate for it
        next_fastOscFreq.nominalMhz = MHZ_NONE;
        next_fastOscFreq.reserved = 1'b1;
      end
    endcase
  end

  // Trim decode: flipping the sign bit maps signed -32..31 onto 0..63,
  // so a larger index is always a faster oscillator
  always_comb begin
    next_fastOscTrim.stepIndex = {~hfTrimValue[TRIM_W-1], hfTrimValue[TRIM_W-2:0]};
    next_fastOscTrim.atMax = (hfTrimValue == TRIM_MAX);
    next_fastOscTrim.atMin = (hfTrimValue == TRIM_MIN);
    next_fastOscTrim.atCentre = (hfTrimValue == TRIM_CENTRE);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fastOscFreq <= '0;
      fastOscTrim <= '0;
    end else begin
      fastOscFreq <= next_fastOscFreq;
      fastOscTrim <= next_fastOscTrim;
    end
  end

  // Register read: data stand for one cycle after the strobe, zero otherwise
  always_comb begin
    next_regRdData = '0;
    next_regRdValid = regRead;
    if (regRead) begin
      unique case (regAddr)
        ADDR_FREQ_SELECT: next_regRdData = {5'h00, hfFreqSelect};
        ADDR_TUNING: next_regRdData = {2'h0, hfTrimValue};
        ADDR_SWITCH_REQUEST: next_regRdData = switchRequest;
        ADDR_CURRENT_SOURCE: next_regRdData = currentSource;
        ADDR_SWITCH_CONTROL: begin
          next_regRdData = switchControl;
          next_regRdData[SWITCH_READY_BIT] = ~switchPending;
          next_regRdData[SWITCH_PENDING_BIT] = switchPending;
        end
        ADDR_READY_FLAGS: next_regRdData = readyFlags;
        ADDR_MANUAL_ENABLES: next_regRdData = manualEnables;
        default: next_regRdData = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      regRdData <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdData <= next_regRdData;
      regRdValid <= next_regRdValid;
    end
  end

endmodule

// File: tb/internal_osc_freq_tune_chk.sv
// Purpose: Port checker for the oscillator tune block
// Assumes: Synchronous active-low reset, one clock
// Notes: Decoded outputs lag their fields by one cycle
`timescale 1ns/1ps
module internal_osc_freq_tune_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [2:0] resetOscChoice,
  input wire logic [osc_tune_pkg::ADDR_W-1:0] regAddr,
  input wire logic [osc_tune_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [osc_tune_pkg::OSC_COUNT-1:0] oscModuleRequest,
  input wire logic [osc_tune_pkg::DATA_W-1:0] regRdData,
  input wire logic regRdValid,
  input wire logic [osc_tune_pkg::FREQ_SEL_W-1:0] hfFreqSelect,
  input wire logic [osc_tune_pkg::TRIM_W-1:0] hfTrimValue,
  input wire osc_tune_pkg::freqInfo_type fastOscFreq,
  input wire osc_tune_pkg::trimStatus_type fastOscTrim,
  input wire logic [osc_tune_pkg::OSC_COUNT-1:0] oscRun
);
  import osc_tune_pkg::*;
  localparam logic [5:0] MHZ_TAB [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20, 6'h00};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // First edge after release still shows reset values, hence the past guard
  property p_decode; $past(rst_b) |-> fastOscFreq.nominalMhz == MHZ_TAB[$past(hfFreqSelect)]
    && fastOscFreq.reserved == ($past(hfFreqSelect) == 3'h7); endproperty
  a_decode: assert property (p_decode) else $error("frequency decode wrong");
  property p_strap1; $rose(rst_b) && $past(resetOscChoice) == 3'h6 |-> hfFreqSelect == 3'h2; endproperty
  a_strap1: assert property (p_strap1) else $error("select after 1 MHz strap wrong");
  property p_strap32; $rose(rst_b) && $past(resetOscChoice) == 3'h0 |-> hfFreqSelect == 3'h6; endproperty
  a_strap32: assert property (p_strap32) else $error("select after 32 MHz strap wrong");
  property p_max; $past(rst_b) && $past(hfTrimValue) == 6'h1F |-> fastOscTrim.atMax && fastOscTrim.stepIndex == 6'h3F;
  endproperty
  a_max: assert property (p_max) else $error("trim maximum wrong");
  property p_min; $past(rst_b) && $past(hfTrimValue) == 6'h20 |-> fastOscTrim.atMin && fastOscTrim.stepIndex == 6'h00;
  endproperty
  a_min: assert property (p_min) else $error("trim minimum wrong");
  property p_centre; $rose(rst_b) |-> hfTrimValue == 6'h00 ##1 fastOscTrim.atCentre; endproperty
  a_centre: assert property (p_centre) else $error("trim default wrong");
  property p_rdsel; regRead && regAddr == 4'h0 |=> regRdValid && regRdData == {5'h00, $past(hfFreqSelect)}; endproperty
  a_rdsel: assert property (p_rdsel) else $error("select readback wrong");
  property p_rdtrim; regRead && regAddr == 4'h1 |=> regRdValid && regRdData == {2'h0, $past(hfTrimValue)}; endproperty
  a_rdtrim: assert property (p_rdtrim) else $error("trim readback wrong");
  property p_step; $past(rst_b) |-> fastOscTrim.stepIndex == ($past(hfTrimValue) ^ 6'h20); endproperty
  a_step: assert property (p_step) else $error("trim step index wrong");
  property p_run; $past(rst_b) |-> ($past(oscModuleRequest) & ~oscRun) == 5'h00; endproperty
  a_run: assert property (p_run) else $error("requested oscillator not running");
endmodule

// File: tb/internal_osc_freq_tune_test.sv
// Purpose: Self-checking bench for the oscillator tune block
// Assumes: Register addresses from the package
// Notes: No partner model; the bench drives every port
`timescale 1ns/1ps
module internal_osc_freq_tune_test;
  import osc_tune_pkg::*;
  localparam logic [5:0] MHZ_TAB [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20, 6'h00};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] resetOscChoice = 3'h6;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [OSC_COUNT-1:0] oscModuleRequest = 5'h00;
  logic [DATA_W-1:0] regRdData;
  logic regRdValid;
  logic [FREQ_SEL_W-1:0] hfFreqSelect;
  logic [TRIM_W-1:0] hfTrimValue;
  freqInfo_type fastOscFreq;
  trimStatus_type fastOscTrim;
  logic [OSC_COUNT-1:0] oscRun;
  int errors = 0;
  int compares = 0;
  internal_osc_freq_tune dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .resetOscChoice(resetOscChoice),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .oscModuleRequest(oscModuleRequest), .regRdData(regRdData), .regRdValid(regRdValid),
    .hfFreqSelect(hfFreqSelect), .hfTrimValue(hfTrimValue), .fastOscFreq(fastOscFreq),
    .fastOscTrim(fastOscTrim), .oscRun(oscRun));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    chk("rdValid", {7'h00, regRdValid}, 8'h01);
    chk(what, regRdData, exp);
  endtask
  task automatic t_reset(input logic [2:0] strap, input logic [2:0] expSel);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    resetOscChoice <= strap;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk("sel", {5'h00, hfFreqSelect}, {5'h00, expSel});
    chk("trim", {2'h0, hfTrimValue}, 8'h00);
    rd(ADDR_FREQ_SELECT, {5'h00, expSel}, "rdSel");
    chk("centre", {fastOscTrim.stepIndex, fastOscTrim.atCentre, fastOscTrim.atMax}, 8'h82);
  endtask
  task automatic t_freq;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_FREQ_SELECT, 8'hF8 | 8'(c));
      rd(ADDR_FREQ_SELECT, 8'(c), "rdFreq");
      chk("mhz", {2'h0, fastOscFreq.nominalMhz}, {2'h0, MHZ_TAB[c]});
      chk("rsv", {7'h00, fastOscFreq.reserved}, {7'h00, c == 7});
    end
  endtask
  task automatic t_trim;
    for (int v = 0; v < 64; v++) begin
      wr(ADDR_TUNING, 8'hC0 | 8'(v));
      @(posedge sys_clk);
      #1;
      chk("step", {2'h0, fastOscTrim.stepIndex}, 8'(v) ^ 8'h20);
      chk("ends", {5'h00, fastOscTrim.atMax, fastOscTrim.atMin, fastOscTrim.atCentre},
          {5'h00, v == 31, v == 32, v == 0});
    end
    rd(ADDR_TUNING, 8'h3F, "rdTrim");
  endtask
  task automatic t_run;
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_MANUAL_ENABLES, 8'h01 << (i == 0 ? 2 : i + 3));
      @(posedge sys_clk);
      #1;
      chk("runMan", {3'h0, oscRun}, 8'h01 << i);
    end
    wr(ADDR_MANUAL_ENABLES, 8'hFF);
    rd(ADDR_MANUAL_ENABLES, 8'hF4, "rdEn");
    wr(ADDR_MANUAL_ENABLES, 8'h00);
    @(posedge sys_clk);
    oscModuleRequest <= 5'h0A;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("runReq", {3'h0, oscRun}, 8'h0A);
    @(posedge sys_clk);
    oscModuleRequest <= 5'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("runOff", {3'h0, oscRun}, 8'h00);
    rd(4'h9, 8'h00, "rdHole");
  endtask
  // Switch registers are only stored; current source follows the request unless held
  task automatic t_switch;
    wr(ADDR_SWITCH_REQUEST, 8'hFF);
    rd(ADDR_SWITCH_REQUEST, 8'h7F, "rdReq");
    rd(ADDR_CURRENT_SOURCE, 8'h7F, "rdCur");
    rd(ADDR_SWITCH_CONTROL, 8'h10, "rdCtlIdle");
    wr(ADDR_SWITCH_CONTROL, 8'hFF);
    wr(ADDR_SWITCH_REQUEST, 8'h11);
    rd(ADDR_CURRENT_SOURCE, 8'h7F, "rdCurHeld");
    rd(ADDR_SWITCH_CONTROL, 8'h88, "rdCtlHeld");
    wr(ADDR_SWITCH_CONTROL, 8'h00);
    rd(ADDR_CURRENT_SOURCE, 8'h11, "rdCurGo");
    wr(ADDR_CURRENT_SOURCE, 8'hFF);
    rd(ADDR_CURRENT_SOURCE, 8'h11, "rdCurRo");
    wr(ADDR_MANUAL_ENABLES, 8'h40);
    @(posedge sys_clk);
    rd(ADDR_READY_FLAGS, 8'h40, "rdReady");
    wr(ADDR_MANUAL_ENABLES, 8'h00);
  endtask
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    t_reset(3'h6, 3'h2);
    t_reset(3'h0, 3'h6);
    t_reset(3'h3, 3'h2);
    t_freq;
    t_trim;
    t_run;
    t_switch;
    // Mid-run reset with trim and select away from their defaults
    t_reset(3'h0, 3'h6);
    rd(ADDR_SWITCH_REQUEST, 8'h00, "rdReqRst");
    end_sim;
  end
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    end_sim;
  end
endmodule
bind internal_osc_freq_tune internal_osc_freq_tune_chk chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
  .resetOscChoice(resetOscChoice), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .oscModuleRequest(oscModuleRequest), .regRdData(regRdData), .regRdValid(regRdValid),
  .hfFreqSelect(hfFreqSelect), .hfTrimValue(hfTrimValue), .fastOscFreq(fastOscFreq),
  .fastOscTrim(fastOscTrim), .oscRun(oscRun));
